//--- pkg/asu_pkg.sv
// package for the async serial transmitter: offsets, fields, states
// assumes a 32-bit apb register bus and a single clock domain
package asu_pkg;
    // register indices, byte address is four times the index
    localparam logic [5:0] ASU_CTRL_IDX = 6'h00;
    localparam logic [5:0] ASU_STAT_IDX = 6'h01;
    localparam logic [5:0] ASU_DATA_IDX = 6'h02;
    localparam logic [5:0] ASU_NINTH_IDX = 6'h03;
    localparam logic [5:0] ASU_BAUD_IDX = 6'h04;
    localparam logic [5:0] ASU_CFG2_IDX = 6'h1E;
    localparam int ASU_ADDR_W = 8;
    // reset values
    localparam logic [7:0] ASU_BAUD_RST = 8'h00;
    localparam logic ASU_CFG2_RST = 1'b0;
    // frame geometry and bit timing in rt ticks
    localparam logic [3:0] ASU_LEN8 = 4'hA;
    localparam logic [3:0] ASU_LEN9 = 4'hB;
    localparam logic [3:0] ASU_RT_LAST = 4'hF;
    localparam logic [3:0] ASU_RT_MID = 4'h7;
    localparam logic [11:0] ASU_ONES = 12'hFFF;

    typedef struct packed {
        logic rx_enable;
        logic tc_irq_enable;
        logic te_irq_enable;
        logic long_break_select;
        logic send_break;
        logic tx_invert;
        logic char9;
        logic tx_enable;
        logic module_enable;
    } asu_ctrl_t;
    localparam asu_ctrl_t ASU_CTRL_RST = 9'h000;

    typedef struct packed {
        logic break_flag;
        logic framing_error_flag;
        logic rx_full_flag;
        logic tx_complete_flag;
        logic tx_empty_flag;
    } asu_stat_t;
    localparam asu_stat_t ASU_STAT_RST = 5'h03;

    typedef enum logic [2:0] {
        ASU_TX_OFF = 3'b000,
        ASU_TX_PRE = 3'b001,
        ASU_TX_DATA = 3'b011,
        ASU_TX_IDLE = 3'b010,
        ASU_TX_BREAK = 3'b110,
        ASU_TX_TAIL = 3'b111
    } asu_tx_state_t;

    typedef enum logic [1:0] {
        ASU_RX_HUNT = 2'b00,
        ASU_RX_FRAME = 2'b01,
        ASU_RX_EXTRA = 2'b11
    } asu_rx_state_t;
endpackage

//--- core/asu_core.sv
// async serial unit: transmitter, break/idle generation, minimal receiver
// assumes an apb master on CLK and an asynchronous serial line on RXD_I
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/100ps
module asu_core
    import asu_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [asu_pkg::ASU_ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // serial pins
    input wire logic RXD_I,
    output logic TXD_O,
    output logic TXD_OE,
    // transmitter interrupt request
    output logic TX_IRQ
);
    import asu_pkg::*;

    function automatic logic [3:0] frame_len(input logic nine);
        frame_len = nine ? ASU_LEN9 : ASU_LEN8;
    endfunction

    asu_ctrl_t ctrl_reg;
    asu_stat_t stat_reg;
    logic tx_empty_reg, tx_cmpl_reg, rx_full_reg, fe_flag_reg, brk_flag_reg;
    logic [7:0] tx_buf_reg;
    logic tx_ninth_reg;
    logic [7:0] rx_data_reg;
    logic rx_ninth_reg;
    logic [7:0] baud_div_reg;
    logic baud_src_reg;
    logic armed_reg;
    logic pready_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic [31:0] rd_data;
    logic rd_err;
    logic [5:0] idx;
    logic acc;
    logic wr_ctrl, wr_data, wr_ninth, wr_baud, wr_cfg2, rd_stat, rd_rxdata;

    logic [7:0] pre_reg;
    logic half_reg;
    logic rt_tick_reg;

    asu_tx_state_t tx_st_reg;
    asu_tx_state_t sel;
    logic [11:0] sh_reg;
    logic [11:0] pattern;
    logic [3:0] left_reg;
    logic [3:0] len;
    logic [3:0] tx_rt_reg;
    logic idle_q_reg;
    logic te_prev_reg;
    logic te_rise, bit_end, half_end, short_brk, char_done, go, load_data;
    logic txd_reg, txd_oe_reg, tx_irq_reg;

    logic rxd_s1_reg, rxd_s2_reg;
    asu_rx_state_t rx_st_reg;
    logic [3:0] rx_rt_reg;
    logic [3:0] rx_idx_reg;
    logic [11:0] rx_sh_reg;
    logic rx_done_reg, rx_fe_reg, brk_det_reg;

    // apb decode
    assign idx = PADDR[ASU_ADDR_W-1:2];
    assign acc = PSEL & PENABLE & pready_reg;
    assign wr_ctrl = acc & PWRITE & (idx == ASU_CTRL_IDX);
    assign wr_data = acc & PWRITE & (idx == ASU_DATA_IDX);
    assign wr_ninth = acc & PWRITE & (idx == ASU_NINTH_IDX);
    assign wr_baud = acc & PWRITE & (idx == ASU_BAUD_IDX);
    assign wr_cfg2 = acc & PWRITE & (idx == ASU_CFG2_IDX);
    assign rd_stat = acc & ~PWRITE & (idx == ASU_STAT_IDX);
    assign rd_rxdata = acc & ~PWRITE & (idx == ASU_DATA_IDX);

    always_comb
    begin
        rd_data = 32'h0000_0000;
        rd_err = 1'b0;
        if (PADDR[1:0] != 2'h0)
            rd_err = 1'b1;
        else if (idx == ASU_CTRL_IDX)
            rd_data = {23'h0, ctrl_reg};
        else if (idx == ASU_STAT_IDX)
            rd_data = {27'h0, stat_reg};
        else if (idx == ASU_DATA_IDX)
            rd_data = {24'h000000, rx_data_reg};
        else if (idx == ASU_NINTH_IDX)
            rd_data = {30'h0, rx_ninth_reg, tx_ninth_reg};
        else if (idx == ASU_BAUD_IDX)
            rd_data = {24'h000000, baud_div_reg};
        else if (idx == ASU_CFG2_IDX)
            rd_data = {31'h0, baud_src_reg};
        else
            rd_err = 1'b1;
    end

    // one wait-free access cycle after setup
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            pready_reg <= PSEL & ~PENABLE;
            if (PSEL & ~PENABLE)
            begin
                prdata_reg <= PWRITE ? 32'h0000_0000 : rd_data;
                pslverr_reg <= rd_err;
            end
        end
    end

    // software-written registers
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            ctrl_reg <= ASU_CTRL_RST;
            tx_buf_reg <= 8'h00;
            tx_ninth_reg <= 1'b0;
            baud_div_reg <= ASU_BAUD_RST;
            baud_src_reg <= ASU_CFG2_RST;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_reg <= asu_ctrl_t'(PWDATA[8:0]);
            if (wr_data & armed_reg)
                tx_buf_reg <= PWDATA[7:0];
            if (wr_ninth)
                tx_ninth_reg <= PWDATA[0];
            if (wr_baud)
                baud_div_reg <= PWDATA[7:0];
            if (wr_cfg2)
                baud_src_reg <= PWDATA[0];
        end
    end

    // status read arms the empty-flag clear
    always_ff @(posedge CLK)
    begin
        if (RST)
            armed_reg <= 1'b0;
        else if (rd_stat)
            armed_reg <= 1'b1;
        else if (wr_data)
            armed_reg <= 1'b0;
    end

    // transmit flags, set wins over clear
    always_ff @(posedge CLK)
    begin
        if (RST || !ctrl_reg.module_enable)
        begin
            tx_empty_reg <= 1'b1;
            tx_cmpl_reg <= 1'b1;
        end
        else
        begin
            if (load_data || (char_done && !ctrl_reg.tx_enable))
                tx_empty_reg <= 1'b1;
            else if (wr_data && armed_reg)
                tx_empty_reg <= 1'b0;
            if (tx_st_reg == ASU_TX_OFF && !go && tx_empty_reg &&
                !ctrl_reg.send_break)
                tx_cmpl_reg <= 1'b1;
            else if ((wr_data && armed_reg) || go)
                tx_cmpl_reg <= 1'b0;
        end
    end

    // rt tick, sixteen per bit, source selectable
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            pre_reg <= 8'h00;
            half_reg <= 1'b0;
            rt_tick_reg <= 1'b0;
        end
        else
        begin
            half_reg <= ~half_reg;
            if (baud_src_reg || half_reg)
            begin
                if (pre_reg >= baud_div_reg)
                begin
                    pre_reg <= 8'h00;
                    rt_tick_reg <= 1'b1;
                end
                else
                begin
                    pre_reg <= pre_reg + 8'h01;
                    rt_tick_reg <= 1'b0;
                end
            end
            else
                rt_tick_reg <= 1'b0;
        end
    end

    // transmitter control
    assign te_rise = ctrl_reg.tx_enable & ~te_prev_reg;
    assign bit_end = rt_tick_reg & (tx_rt_reg == ASU_RT_LAST);
    assign half_end = rt_tick_reg & (tx_rt_reg == ASU_RT_MID);
    assign short_brk = (tx_st_reg == ASU_TX_BREAK) & ~ctrl_reg.send_break
        & idle_q_reg & stat_reg.tx_empty_flag;
    assign char_done = (tx_st_reg != ASU_TX_OFF) & (left_reg == 4'h1)
        & (bit_end | (short_brk & half_end));

    always_comb
    begin
        sel = ASU_TX_OFF;
        if (!ctrl_reg.tx_enable)
            sel = ASU_TX_OFF;
        else if (tx_st_reg == ASU_TX_OFF && te_rise)
            sel = ASU_TX_PRE;
        else if (ctrl_reg.send_break)
            sel = ASU_TX_BREAK;
        else if (tx_st_reg == ASU_TX_BREAK && !idle_q_reg)
            sel = ASU_TX_TAIL;
        else if (idle_q_reg)
            sel = ASU_TX_IDLE;
        else if (!stat_reg.tx_empty_flag)
            sel = ASU_TX_DATA;
        go = (tx_st_reg == ASU_TX_OFF) ? (sel != ASU_TX_OFF) : char_done;
        load_data = go & (sel == ASU_TX_DATA);
    end

    always_comb
    begin
        len = frame_len(ctrl_reg.char9);
        pattern = ASU_ONES;
        case (sel)
            ASU_TX_DATA:
                if (ctrl_reg.char9)
                    pattern = {2'b11, tx_ninth_reg, tx_buf_reg, 1'b0};
                else
                    pattern = {3'b111, tx_buf_reg, 1'b0};
            ASU_TX_BREAK:
            begin
                pattern = 12'h000;
                len = len + {3'h0, ctrl_reg.long_break_select};
            end
            ASU_TX_TAIL:
                len = 4'h1;
            default:
                pattern = ASU_ONES;
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (RST || !ctrl_reg.module_enable)
            te_prev_reg <= 1'b0;
        else
            te_prev_reg <= ctrl_reg.tx_enable;
    end

    always_ff @(posedge CLK)
    begin
        if (RST || !ctrl_reg.module_enable)
        begin
            tx_st_reg <= ASU_TX_OFF;
            sh_reg <= ASU_ONES;
            left_reg <= 4'h0;
            tx_rt_reg <= 4'h0;
        end
        else if (go)
        begin
            tx_st_reg <= sel;
            sh_reg <= pattern;
            left_reg <= len;
            tx_rt_reg <= 4'h0;
        end
        else if (char_done)
        begin
            tx_st_reg <= ASU_TX_OFF;
            sh_reg <= ASU_ONES;
        end
        else if (tx_st_reg != ASU_TX_OFF && rt_tick_reg)
        begin
            tx_rt_reg <= tx_rt_reg + 4'h1;
            if (bit_end)
            begin
                sh_reg <= {1'b1, sh_reg[11:1]};
                left_reg <= left_reg - 4'h1;
            end
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST || !ctrl_reg.module_enable)
            idle_q_reg <= 1'b0;
        else if (go && sel == ASU_TX_IDLE)
            idle_q_reg <= 1'b0;
        else if (tx_st_reg != ASU_TX_OFF && te_rise)
            idle_q_reg <= 1'b1;
    end

    // pins and interrupt request
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            txd_reg <= 1'b1;
            txd_oe_reg <= 1'b0;
            tx_irq_reg <= 1'b0;
        end
        else
        begin
            txd_reg <= sh_reg[0] ^ ctrl_reg.tx_invert;
            txd_oe_reg <= ctrl_reg.module_enable;
            tx_irq_reg <= ctrl_reg.module_enable &
                ((stat_reg.tx_empty_flag & ctrl_reg.te_irq_enable) |
                (stat_reg.tx_complete_flag & ctrl_reg.tc_irq_enable));
        end
    end

    // receive line synchroniser
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            rxd_s1_reg <= 1'b1;
            rxd_s2_reg <= 1'b1;
        end
        else
        begin
            rxd_s1_reg <= RXD_I;
            rxd_s2_reg <= rxd_s1_reg;
        end
    end

    // receiver framing and break detection
    always_ff @(posedge CLK)
    begin
        if (RST || !ctrl_reg.module_enable || !ctrl_reg.rx_enable)
        begin
            rx_st_reg <= ASU_RX_HUNT;
            rx_rt_reg <= 4'h0;
            rx_idx_reg <= 4'h0;
            rx_sh_reg <= 12'h000;
            rx_done_reg <= 1'b0;
            rx_fe_reg <= 1'b0;
            brk_det_reg <= 1'b0;
        end
        else
        begin
            rx_done_reg <= 1'b0;
            brk_det_reg <= 1'b0;
            case (rx_st_reg)
                ASU_RX_HUNT:
                    if (rt_tick_reg && !rxd_s2_reg)
                    begin
                        rx_st_reg <= ASU_RX_FRAME;
                        rx_rt_reg <= 4'h0;
                        rx_idx_reg <= 4'h0;
                        rx_sh_reg <= 12'h000;
                    end
                ASU_RX_FRAME:
                    if (rt_tick_reg)
                    begin
                        rx_rt_reg <= rx_rt_reg + 4'h1;
                        if (rx_rt_reg == ASU_RT_MID)
                        begin
                            rx_sh_reg[rx_idx_reg] <= rxd_s2_reg;
                            rx_idx_reg <= rx_idx_reg + 4'h1;
                            if (rx_idx_reg == frame_len(ctrl_reg.char9) - 4'h1)
                            begin
                                rx_st_reg <= ASU_RX_HUNT;
                                if (rx_sh_reg == 12'h000 && !rxd_s2_reg)
                                begin
                                    if (ctrl_reg.long_break_select)
                                        rx_st_reg <= ASU_RX_EXTRA;
                                    else
                                        brk_det_reg <= 1'b1;
                                end
                                else
                                begin
                                    rx_done_reg <= 1'b1;
                                    rx_fe_reg <= ~rxd_s2_reg;
                                end
                            end
                        end
                    end
                default:
                    if (rt_tick_reg)
                    begin
                        rx_rt_reg <= rx_rt_reg + 4'h1;
                        if (rx_rt_reg == ASU_RT_MID)
                        begin
                            rx_st_reg <= ASU_RX_HUNT;
                            brk_det_reg <= ~rxd_s2_reg;
                            rx_done_reg <= rxd_s2_reg;
                            rx_fe_reg <= 1'b1;
                        end
                    end
            endcase
        end
    end

    // receive flags and data, set wins over the read clear
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            rx_data_reg <= 8'h00;
            rx_ninth_reg <= 1'b0;
            rx_full_reg <= 1'b0;
            fe_flag_reg <= 1'b0;
            brk_flag_reg <= 1'b0;
        end
        else if (brk_det_reg)
        begin
            rx_data_reg <= 8'h00;
            rx_ninth_reg <= 1'b0;
            rx_full_reg <= 1'b1;
            fe_flag_reg <= 1'b1;
            brk_flag_reg <= 1'b1;
        end
        else if (rx_done_reg)
        begin
            rx_data_reg <= rx_sh_reg[8:1];
            rx_ninth_reg <= ctrl_reg.char9 ? rx_sh_reg[9] : rx_sh_reg[8];
            rx_full_reg <= 1'b1;
            fe_flag_reg <= rx_fe_reg;
        end
        else if (rd_rxdata)
        begin
            rx_full_reg <= 1'b0;
            fe_flag_reg <= 1'b0;
            brk_flag_reg <= 1'b0;
        end
    end

    assign stat_reg = asu_stat_t'({brk_flag_reg, fe_flag_reg, rx_full_reg,
        tx_cmpl_reg, tx_empty_reg});
    assign PRDATA = prdata_reg;
    assign PREADY = pready_reg;
    assign PSLVERR = pslverr_reg;
    assign TXD_O = txd_reg;
    assign TXD_OE = txd_oe_reg;
    assign TX_IRQ = tx_irq_reg;

    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_break_low: assert property ((tx_st_reg == ASU_TX_BREAK) &&
        !ctrl_reg.tx_invert |=> !TXD_O)
        else $error("break not low");
    a_idle_high: assert property ((tx_st_reg == ASU_TX_OFF) &&
        !ctrl_reg.tx_invert && ctrl_reg.module_enable |=> TXD_O)
        else $error("idle line not high");
    a_invert_idle: assert property ((tx_st_reg == ASU_TX_OFF) &&
        ctrl_reg.tx_invert && ctrl_reg.module_enable |=> !TXD_O)
        else $error("inverted idle not low");
    a_pin_release: assert property (!ctrl_reg.module_enable
        |=> !TXD_OE)
        else $error("pin not released");
    a_empty_clear: assert property ($fell(stat_reg.tx_empty_flag)
        |-> $past(wr_data && armed_reg))
        else $error("empty flag cleared without sequence");
    a_start_load: assert property (load_data |=>
        (sh_reg[0] == 1'b0) && stat_reg.tx_empty_flag &&
        (tx_st_reg == ASU_TX_DATA))
        else $error("bad character load");
    a_preamble_first: assert property ((tx_st_reg == ASU_TX_OFF) &&
        te_rise && ctrl_reg.module_enable |=> (tx_st_reg == ASU_TX_PRE))
        else $error("missing preamble");
    a_break_flags: assert property (brk_det_reg |=>
        stat_reg.break_flag && stat_reg.framing_error_flag &&
        stat_reg.rx_full_flag && (rx_data_reg == 8'h00) && !rx_ninth_reg)
        else $error("break flags wrong");
    a_ninth_copy: assert property (rx_done_reg && !ctrl_reg.char9
        |=> rx_ninth_reg == rx_data_reg[7])
        else $error("ninth bit not copy of bit 7");
    a_irq_empty: assert property (ctrl_reg.module_enable &&
        stat_reg.tx_empty_flag && ctrl_reg.te_irq_enable |=> TX_IRQ)
        else $error("empty irq missing");

    c_data_frame: cover property (load_data ##[1:300] char_done);
    c_break_tail: cover property ((tx_st_reg == ASU_TX_BREAK)
        ##1 (tx_st_reg == ASU_TX_TAIL));
    c_idle_queued: cover property (go && sel == ASU_TX_IDLE);
    c_rx_break: cover property (brk_det_reg);
endmodule // asu_core

//--- tb/asu_remote.sv
// remote serial device: decodes frames from the pin, sends zeros back
// assumes a fixed bit time of BITC clocks
`timescale 1ns/100ps
module asu_remote #(
    parameter int BITC = 16
) (
    // clock and line
    input wire logic clk,
    input wire logic txd,
    input wire logic inv,
    input wire logic nine,
    // line into the device
    output logic rxd,
    // decoded character, stop bit on top
    output logic got,
    output logic [9:0] ch
);
    initial
    begin
        rxd = 1'b1;
        got = 1'b0;
        ch = 10'h000;
    end
    always
    begin
        @(posedge clk);
        if ((txd ^ inv) === 1'b0)
        begin
            repeat (BITC / 2) @(posedge clk);
            if ((txd ^ inv) === 1'b0) // start bit low
            begin
                ch = 10'h000;
                for (int i = 0; i < (nine ? 10 : 9); i++)
                begin
                    repeat (BITC) @(posedge clk);
                    ch[i] = txd ^ inv;
                end
                got <= 1'b1;
                @(posedge clk);
                got <= 1'b0;
            end
        end
    end
    task automatic send_zeros(input int n);
        rxd <= 1'b0;
        repeat (n * BITC) @(posedge clk);
        rxd <= 1'b1;
    endtask
endmodule // asu_remote

//--- tb/tb_top.sv
// bench for the async serial unit: apb master, remote line model
// assumes fast baud source and divisor 0, so a bit is 16 clocks
`timescale 1ns/100ps
`define CHK(nm, ex, sn) begin total_checks++; if ((sn) !== (ex)) begin \
    n_mismatch++; $display("[ERR] %s expected %h seen %h", nm, ex, sn); \
    end end
module tb_top;
    import asu_pkg::*;
    logic clk, rst, psel, penable, pwrite, rd_chk, inv, c9;
    logic pready, pslverr, rxd, txd, txd_oe, tx_irq, got;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [9:0] ch, es;
    logic [32:0] er;
    wire logic pin = txd_oe ? txd : 1'b1;
    int n_mismatch = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [32:0] exp_rd[$];
    logic [9:0] exp_ser[$];
    asu_core DUT (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .RXD_I(rxd), .TXD_O(txd),
        .TXD_OE(txd_oe), .TX_IRQ(tx_irq));
    asu_remote #(.BITC(16)) rm (.clk(clk), .txd(pin), .inv(inv),
        .nine(c9), .rxd(rxd), .got(got), .ch(ch));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic c, input logic [32:0] e);
        if (c)
            exp_rd.push_back(e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        rd_chk <= c;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic send(input logic [7:0] b, input logic n,
        input logic nine);
        q = 32'h0;
        for (int k = 0; k < 400 && q[0] !== 1'b1; k++)
            apb(1'b0, 8'h04, 32'h0, 1'b0, 33'h0);
        if (nine)
            apb(1'b1, 8'h0C, {31'h0, n}, 1'b0, 33'h0);
        apb(1'b1, 8'h08, {24'h0, b}, 1'b0, 33'h0);
        exp_ser.push_back(nine ? {1'b1, n, b} : {2'b01, b});
    endtask
    task automatic drain();
        for (int k = 0; k < 4000 && exp_ser.size() > 0; k++)
            @(posedge clk);
        `CHK("left", 32'h0, exp_ser.size())
        repeat (40) @(posedge clk);
    endtask
    task automatic done_t(input string s);
        $display("test %s finished", s);
    endtask
    always @(posedge clk)
    begin
        if (psel && penable && pready === 1'b1 && rd_chk && !pwrite)
        begin
            er = exp_rd.pop_front();
            `CHK("read", er, {pslverr, prdata})
        end
        if (got === 1'b1)
        begin
            es = exp_ser.pop_front();
            `CHK("char", es, ch)
        end
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    initial
    begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        rd_chk = 1'b0;
        inv = 1'b0;
        c9 = 1'b0;
        q = $urandom(32'h2F21);
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, 8'h04, 32'h0, 1'b1, {1'b0, 32'h3});
        apb(1'b0, 8'h14, 32'h0, 1'b1, {1'b1, 32'h0});
        done_t("reset");
        apb(1'b1, 8'h78, 32'h1, 1'b0, 33'h0);
        apb(1'b1, 8'h00, 32'h103, 1'b0, 33'h0);
        repeat (2) @(posedge clk);
        `CHK("oe", 1'b1, txd_oe)
        `CHK("idle", 1'b1, txd)
        repeat (3) send(8'($urandom_range(255)), 1'b0, 1'b0);
        drain();
        apb(1'b0, 8'h04, 32'h0, 1'b1, {1'b0, 32'h3});
        done_t("tx");
        apb(1'b1, 8'h00, 32'h10B, 1'b0, 33'h0);
        @(posedge clk);
        inv <= 1'b1;
        send(8'($urandom_range(255)), 1'b0, 1'b0);
        drain();
        apb(1'b1, 8'h00, 32'h103, 1'b0, 33'h0);
        @(posedge clk);
        inv <= 1'b0;
        done_t("invert");
        rm.send_zeros(11);
        repeat (64) @(posedge clk);
        apb(1'b0, 8'h04, 32'h0, 1'b1, {1'b0, 32'h1F});
        apb(1'b0, 8'h08, 32'h0, 1'b1, {1'b0, 32'h0});
        apb(1'b0, 8'h0C, 32'h0, 1'b1, {1'b0, 32'h0});
        apb(1'b0, 8'h04, 32'h0, 1'b1, {1'b0, 32'h3});
        done_t("break");
        apb(1'b1, 8'h00, 32'h007, 1'b0, 33'h0);
        c9 <= 1'b1;
        send(8'($urandom_range(255)), 1'($urandom_range(1)), 1'b1);
        drain();
        done_t("nine");
        exp_ser.push_back(10'h000);
        apb(1'b1, 8'h00, 32'h013, 1'b0, 33'h0);
        c9 <= 1'b0;
        apb(1'b1, 8'h00, 32'h003, 1'b0, 33'h0);
        drain();
        apb(1'b0, 8'h04, 32'h0, 1'b1, {1'b0, 32'h3});
        done_t("send break");
        apb(1'b1, 8'h00, 32'h043, 1'b0, 33'h0);
        repeat (2) @(posedge clk);
        `CHK("irq", 1'b1, tx_irq)
        apb(1'b1, 8'h00, 32'h0, 1'b0, 33'h0);
        repeat (2) @(posedge clk);
        `CHK("oe off", 1'b0, txd_oe)
        `CHK("irq off", 1'b0, tx_irq)
        done_t("disable");
        tally_and_finish();
    end
endmodule // tb_top
